/* File: design/txobi_tx_overhead_byte_insertion.sv */
`timescale 1ns/1ps
//
// Contract
// RL1: Insert 48-byte block at row, column.
// RL2: CPU mode uses registers, else overhead stream.
// RL3: Block row/column reset zero; zero inhibits.
// RL4: Short frame: rows above two not inserted.
// RL5: Transparent mode disables all insertion.
// RL6: Insertion data registers are not reset.
// RL7: STS-12 block sends entries 0,4..44 only.
// RL8: STS-12 byte replicated over four positions.
// RL9: Three single bytes at row/column/slot.
// RL10: Single fields reset zero; zero inhibits.
// RL11: STS-12 single slots are multiples of four.
// RL12: Three 16-byte groups, thirds picked by selector.
// RL13: Same position, distinct thirds form 48 run.
// RL14: Group fields reset zero; zero inhibits.
// RL15: STS-12 groups send entries 0,4,8,12.
// RL16: Full frame 9x90x48, 125 us.
// RL17: Short frame 2x6x48, 576 bytes.
// RL18: Stream: 68 ports of 99 bytes ordered.
// RL19: Source starts on raised data-valid.
// RL20: Priority single, then group, then block.
// RL21: Settings change only at frame boundary; staging writes follow insert_cpu_source_sel at once, not act_cpu_src.
//
module txobi_tx_overhead_byte_insertion
  import txobi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Frame and port mode
  input wire logic frm_sync,
  input wire logic short_frame,
  input wire logic sts12_mode,
  input wire logic transparent_mode,
  input wire logic [IDX_W-1:0] port_sel,
  // Insertion configuration
  input wire logic insert_cpu_source_sel,
  input wire logic [FIELD_ROW_W-1:0] block_insert_row,
  input wire logic [FIELD_COL_W-1:0] block_insert_col,
  input wire logic [SINGLE_N*FIELD_ROW_W-1:0] single_insert_row,
  input wire logic [SINGLE_N*FIELD_COL_W-1:0] single_insert_col,
  input wire logic [SINGLE_N*SLOT_W-1:0] single_insert_slot,
  input wire logic [GROUP_N*FIELD_ROW_W-1:0] group16_insert_row,
  input wire logic [GROUP_N*FIELD_COL_W-1:0] group16_insert_col,
  input wire logic [GROUP_N*SEL_W-1:0] group16_third_sel,
  // CPU data write
  input wire logic cpu_wr_en,
  input wire logic [IDX_W-1:0] cpu_wr_addr,
  input wire logic [7:0] cpu_wr_data,
  // Overhead stream
  input wire logic ohmon_valid,
  input wire logic [7:0] ohmon_data_in,
  output logic oh_frame_dv,
  // Transmit data path
  input wire logic [7:0] tx_data_in,
  output logic [7:0] tx_data_out,
  output logic tx_inserted
);

  // ---------------------------------------------------------------
  // Frame position
  // ---------------------------------------------------------------
  txobi_frame_if frm ();

  txobi_frame_cnt u_frame_cnt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .frm_sync(frm_sync),
    .short_frame(short_frame),
    .pos(frm)
  );

  // ---------------------------------------------------------------
  // Position match
  // ---------------------------------------------------------------
  function automatic logic pos_hit(
    input logic [FIELD_ROW_W-1:0] f_row,
    input logic [FIELD_COL_W-1:0] f_col,
    input logic [ROW_W-1:0] cur_row,
    input logic [COL_W-1:0] cur_col,
    input logic short_fmt
  );
    logic on_row;
    logic on_col;
    on_row = (cur_row == f_row - ROW_ONE);
    on_col = (cur_col == {{(COL_W-FIELD_COL_W){1'b0}}, f_col} - COL_ONE);
    pos_hit = (f_row != '0) && (f_col != '0) && on_row && on_col // [RL3] [RL10] [RL14]
      && !(short_fmt && (f_row > SHORT_MAX_ROW)); // [RL4]
  endfunction : pos_hit

  // ---------------------------------------------------------------
  // Active settings, taken at frame boundary
  // ---------------------------------------------------------------
  logic act_cpu_src;
  logic [FIELD_ROW_W-1:0] act_blk_row;
  logic [FIELD_COL_W-1:0] act_blk_col;
  logic [SINGLE_N*FIELD_ROW_W-1:0] act_sgl_row;
  logic [SINGLE_N*FIELD_COL_W-1:0] act_sgl_col;
  logic [SINGLE_N*SLOT_W-1:0] act_sgl_slot;
  logic [GROUP_N*FIELD_ROW_W-1:0] act_grp_row;
  logic [GROUP_N*FIELD_COL_W-1:0] act_grp_col;
  logic [GROUP_N*SEL_W-1:0] act_grp_sel;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      act_cpu_src <= 1'b0;
      act_blk_row <= '0; // [RL3]
      act_blk_col <= '0; // [RL3]
      act_sgl_row <= '0; // [RL10]
      act_sgl_col <= '0; // [RL10]
      act_sgl_slot <= '0; // [RL10]
      act_grp_row <= '0; // [RL14]
      act_grp_col <= '0; // [RL14]
      act_grp_sel <= '0; // [RL14]
    end else if (clk_en && frm.frame_start) begin
      act_cpu_src <= insert_cpu_source_sel; // [RL21]
      act_blk_row <= block_insert_row; // [RL21]
      act_blk_col <= block_insert_col;
      act_sgl_row <= single_insert_row;
      act_sgl_col <= single_insert_col;
      act_sgl_slot <= single_insert_slot;
      act_grp_row <= group16_insert_row;
      act_grp_col <= group16_insert_col;
      act_grp_sel <= group16_third_sel;
    end
  end

  // ---------------------------------------------------------------
  // Overhead stream tracking
  // ---------------------------------------------------------------
  txobi_stream_t st;
  logic [IDX_W-1:0] strm_byte;
  logic [IDX_W-1:0] strm_port;
  logic strm_last;

  assign strm_last = (strm_byte == LAST_BYTE) && (strm_port == LAST_PORT);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= TXOBI_ST_IDLE;
      oh_frame_dv <= 1'b0;
      strm_byte <= '0;
      strm_port <= '0;
    end else if (clk_en) begin
      case (st)
        TXOBI_ST_IDLE, TXOBI_ST_DONE: begin
          if (frm.frame_start) begin
            st <= TXOBI_ST_RUN;
            oh_frame_dv <= 1'b1; // [RL19]
            strm_byte <= '0;
            strm_port <= '0;
          end
        end
        TXOBI_ST_RUN: begin
          if (frm.frame_start) begin
            strm_byte <= '0;
            strm_port <= '0;
          end else if (ohmon_valid) begin
            if (strm_last) begin
              st <= TXOBI_ST_DONE;
              oh_frame_dv <= 1'b0;
            end else if (strm_byte == LAST_BYTE) begin
              strm_byte <= '0; // [RL18]
              strm_port <= strm_port + IDX_ONE;
            end else begin
              strm_byte <= strm_byte + IDX_ONE;
            end
          end
        end
        default: begin
          st <= TXOBI_ST_IDLE;
          oh_frame_dv <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Byte stores: staging filled now, active sent next frame
  // ---------------------------------------------------------------
  logic [7:0] stage_mem [PORT_BYTES];
  logic [7:0] act_mem [PORT_BYTES];
  logic stage_wr;
  logic [IDX_W-1:0] stage_addr;
  logic [7:0] stage_data;

  always_comb begin
    if (insert_cpu_source_sel) begin
      stage_wr = cpu_wr_en && (cpu_wr_addr <= LAST_BYTE); // [RL2]
      stage_addr = cpu_wr_addr;
      stage_data = cpu_wr_data;
    end else begin
      stage_wr = (st == TXOBI_ST_RUN) && ohmon_valid && !frm.frame_start
        && (strm_port == port_sel); // [RL2] [RL18]
      stage_addr = strm_byte;
      stage_data = ohmon_data_in;
    end
  end

  // No reset on data stores
  always_ff @(posedge sys_clk) begin
    if (clk_en && stage_wr) begin
      stage_mem[stage_addr] <= stage_data; // [RL6]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && frm.frame_start) begin
      act_mem <= stage_mem; // [RL21] [RL6]
    end
  end

  // ---------------------------------------------------------------
  // Insertion decode
  // ---------------------------------------------------------------
  logic [SLOT_W-1:0] eff_slot;
  logic [SINGLE_N-1:0] sgl_hit;
  logic [GROUP_N-1:0] grp_hit;
  logic blk_hit;

  // STS-12 byte covers four positions, first entry of each four
  assign eff_slot = sts12_mode ? {frm.slot[SLOT_W-1:2], 2'b00} : frm.slot; // [RL7] [RL8] [RL15]

  assign blk_hit = pos_hit(act_blk_row, act_blk_col, frm.row, frm.col, short_frame); // [RL1]

  genvar gi;
  generate
    for (gi = 0; gi < SINGLE_N; gi++) begin : g_single
      // Slot field trusted as multiple of four in STS-12
      assign sgl_hit[gi] = pos_hit(act_sgl_row[gi*FIELD_ROW_W +: FIELD_ROW_W],
        act_sgl_col[gi*FIELD_COL_W +: FIELD_COL_W], frm.row, frm.col, short_frame)
        && (eff_slot == act_sgl_slot[gi*SLOT_W +: SLOT_W]); // [RL9] [RL11]
    end
    for (gi = 0; gi < GROUP_N; gi++) begin : g_group
      assign grp_hit[gi] = pos_hit(act_grp_row[gi*FIELD_ROW_W +: FIELD_ROW_W],
        act_grp_col[gi*FIELD_COL_W +: FIELD_COL_W], frm.row, frm.col, short_frame)
        && (act_grp_sel[gi*SEL_W +: SEL_W] != '0)
        && ({1'b0, eff_slot[SLOT_W-1:4]} == {1'b0, act_grp_sel[gi*SEL_W +: SEL_W]} - 3'h1); // [RL12] [RL13]
    end
  endgenerate

  logic ins_hit;
  logic [IDX_W-1:0] ins_idx;

  always_comb begin
    ins_hit = 1'b0;
    ins_idx = IDX_ZERO;
    if (blk_hit) begin
      ins_hit = 1'b1;
      ins_idx = BLOCK_BASE + {1'b0, eff_slot}; // [RL1] [RL7]
    end
    for (int g = GROUP_N - 1; g >= 0; g--) begin
      if (grp_hit[g]) begin
        ins_hit = 1'b1;
        ins_idx = GROUP_BASE + IDX_W'(g * GROUP_LEN) + {3'h0, eff_slot[3:0]}; // [RL20] [RL15]
      end
    end
    for (int s = SINGLE_N - 1; s >= 0; s--) begin
      if (sgl_hit[s]) begin
        ins_hit = 1'b1;
        ins_idx = SINGLE_BASE + IDX_W'(s); // [RL20]
      end
    end
    if (transparent_mode) begin
      ins_hit = 1'b0; // [RL5]
    end
  end

  // ---------------------------------------------------------------
  // Transmit output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_data_out <= '0;
      tx_inserted <= 1'b0;
    end else if (clk_en) begin
      tx_inserted <= ins_hit;
      tx_data_out <= ins_hit ? act_mem[ins_idx] : tx_data_in;
    end
  end

endmodule : txobi_tx_overhead_byte_insertion

/* File: design/txobi_pkg.sv */
package txobi_pkg;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int ROW_W = 4;
  localparam int COL_W = 7;
  localparam int SLOT_W = 6;
  localparam logic [ROW_W-1:0] ROWS_FULL = 4'h9;
  localparam logic [COL_W-1:0] COLS_FULL = 7'h5a;
  localparam logic [ROW_W-1:0] ROWS_SHORT = 4'h2;
  localparam logic [COL_W-1:0] COLS_SHORT = 7'h06;
  localparam logic [SLOT_W-1:0] SLOTS = 6'h30;
  localparam logic [ROW_W-1:0] SHORT_MAX_ROW = 4'h2;
  localparam logic [ROW_W-1:0] ROW_ONE = 4'h1;
  localparam logic [COL_W-1:0] COL_ONE = 7'h01;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 6'h01;

  // ---------------------------------------------------------------
  // Insertion groups
  // ---------------------------------------------------------------
  localparam int FIELD_ROW_W = 4;
  localparam int FIELD_COL_W = 2;
  localparam int SEL_W = 2;
  localparam int SINGLE_N = 3;
  localparam int GROUP_N = 3;
  localparam int GROUP_LEN = 16;
  localparam int BLOCK_LEN = 48;
  localparam int PORT_BYTES = 99;
  localparam int IDX_W = 7;
  localparam logic [IDX_W-1:0] SINGLE_BASE = 7'h00;
  localparam logic [IDX_W-1:0] GROUP_BASE = 7'h03;
  localparam logic [IDX_W-1:0] BLOCK_BASE = 7'h33;
  localparam logic [IDX_W-1:0] LAST_BYTE = 7'h62;
  localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;
  localparam logic [IDX_W-1:0] IDX_ZERO = 7'h00;

  // ---------------------------------------------------------------
  // Overhead stream
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] LAST_PORT = 7'h43;

  typedef enum logic [1:0] {
    TXOBI_ST_IDLE = 2'b00,
    TXOBI_ST_RUN = 2'b01,
    TXOBI_ST_DONE = 2'b10
  } txobi_stream_t;

endpackage : txobi_pkg

/* File: design/txobi_frame_if.sv */
`timescale 1ns/1ps
interface txobi_frame_if;
  import txobi_pkg::*;
  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] col;
  logic [SLOT_W-1:0] slot;
  logic frame_start;
  modport gen (output row, col, slot, frame_start);
  modport use_pos (input row, col, slot, frame_start);
endinterface : txobi_frame_if

/* File: design/txobi_frame_cnt.sv */
`timescale 1ns/1ps
module txobi_frame_cnt
  import txobi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Frame control
  input wire logic frm_sync,
  input wire logic short_frame,
  // Position out
  txobi_frame_if.gen pos
);

  logic [ROW_W-1:0] rows;
  logic [COL_W-1:0] cols;
  logic last_slot;
  logic last_col;
  logic last_row;

  assign rows = short_frame ? ROWS_SHORT : ROWS_FULL; // [RL16] [RL17]
  assign cols = short_frame ? COLS_SHORT : COLS_FULL; // [RL16] [RL17]
  assign last_slot = (pos.slot == SLOTS - SLOT_ONE);
  assign last_col = (pos.col >= cols - COL_ONE);
  assign last_row = (pos.row >= rows - ROW_ONE);

  // ---------------------------------------------------------------
  // Row, column, slot counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pos.row <= '0;
      pos.col <= '0;
      pos.slot <= '0;
      pos.frame_start <= 1'b0;
    end else if (clk_en) begin
      pos.frame_start <= frm_sync | (last_slot & last_col & last_row);
      if (frm_sync) begin
        pos.row <= '0;
        pos.col <= '0;
        pos.slot <= '0;
      end else if (!last_slot) begin
        pos.slot <= pos.slot + SLOT_ONE;
      end else begin
        pos.slot <= '0;
        if (!last_col) begin
          pos.col <= pos.col + COL_ONE;
        end else begin
          pos.col <= '0;
          pos.row <= last_row ? '0 : pos.row + ROW_ONE;
        end
      end
    end
  end

endmodule : txobi_frame_cnt

/* File: tb/txobi_checker.sv */
`timescale 1ns/1ps
module txobi_checker
  import txobi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched signals
  input wire logic frm_sync,
  input wire logic transparent_mode,
  input wire logic sts12_mode,
  input wire logic ohmon_valid,
  input wire logic oh_frame_dv,
  input wire logic [7:0] tx_data_in,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_inserted
);
  default clocking cb @(posedge sys_clk);
  endclocking
  property p_rst_out;
    !nrst |=> tx_data_out == 8'h00 && !tx_inserted && !oh_frame_dv;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  property p_rst_idle;
    !nrst ##1 nrst |-> !tx_inserted [*2];
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("insert after reset");
  property p_transp;
    disable iff (!nrst) transparent_mode |=> !tx_inserted;
  endproperty
  a_transp: assert property (p_transp) else $error("insert in transparent");
  property p_pass;
    disable iff (!nrst) $past(nrst) && !tx_inserted |-> tx_data_out == $past(tx_data_in);
  endproperty
  a_pass: assert property (p_pass) else $error("byte not passed");
  property p_dv_start;
    disable iff (!nrst) frm_sync ##1 1'b1 |-> ##[0:2] oh_frame_dv;
  endproperty
  a_dv_start: assert property (p_dv_start) else $error("no data valid");
  property p_dv_hold;
    disable iff (!nrst) oh_frame_dv && !ohmon_valid |=> oh_frame_dv;
  endproperty
  a_dv_hold: assert property (p_dv_hold) else $error("valid fell early");
  property p_dv_min;
    disable iff (!nrst) $rose(oh_frame_dv) |-> oh_frame_dv [*8];
  endproperty
  a_dv_min: assert property (p_dv_min) else $error("valid too short");
  property p_ins_cause;
    disable iff (!nrst) tx_inserted |-> !$past(transparent_mode);
  endproperty
  a_ins_cause: assert property (p_ins_cause) else $error("insert cause");
  c_ins: cover property (tx_inserted);
  c_sts: cover property (sts12_mode && tx_inserted);
  c_tr: cover property (transparent_mode && frm_sync);
endmodule : txobi_checker

bind txobi_tx_overhead_byte_insertion txobi_checker chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .frm_sync(frm_sync), .transparent_mode(transparent_mode), .sts12_mode(sts12_mode),
  .ohmon_valid(ohmon_valid), .oh_frame_dv(oh_frame_dv), .tx_data_in(tx_data_in),
  .tx_data_out(tx_data_out), .tx_inserted(tx_inserted));

/* File: tb/txobi_oh_source.sv */
`timescale 1ns/1ps
module txobi_oh_source (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Frame and pacing
  input wire logic frm_sync,
  input wire logic stall,
  // Overhead stream
  input wire logic oh_frame_dv,
  output logic ohmon_valid,
  output logic [7:0] ohmon_data_in
);
  int cnt = 99;
  int hold = 0;
  initial ohmon_valid = 1'b0;
  initial ohmon_data_in = 8'h00;
  // Port 0 group only, idle gap after frame mark
  always @(posedge sys_clk) begin
    ohmon_valid <= 1'b0;
    ohmon_data_in <= ~ohmon_data_in;
    if (!nrst) begin
      cnt <= 99;
    end else if (frm_sync) begin
      cnt <= 0;
      hold <= 3;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else if (cnt < 99 && oh_frame_dv && !stall) begin
      ohmon_valid <= 1'b1;
      ohmon_data_in <= 8'(cnt * 7 + 3);
      cnt <= cnt + 1;
    end
  end
endmodule : txobi_oh_source

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import txobi_pkg::*;
  typedef struct packed {
    logic [3:0] brow;
    logic [1:0] bcol;
    logic [11:0] srow;
    logic [5:0] scol;
    logic [17:0] sslot;
    logic [11:0] grow;
    logic [5:0] gcol;
    logic [5:0] gsel;
  } txobi_cfg_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic frm_sync = 1'b0;
  logic sts12_mode = 1'b0;
  logic transparent_mode = 1'b0;
  logic cpu_sel = 1'b1;
  logic wr_en = 1'b0;
  logic stall = 1'b0;
  logic [6:0] wr_addr = 7'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, oh_data;
  logic oh_valid, oh_dv, ins;
  logic [31:0] seed = 32'h24c17e60;
  txobi_cfg_t cfg = '0;
  txobi_cfg_t lat = '0;
  logic [7:0] stage [99];
  logic [7:0] act [99];
  int k = 0;
  int error_cnt = 0;
  int n_compared = 0;

  always #12.5 sys_clk = ~sys_clk;

  txobi_tx_overhead_byte_insertion dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
    .frm_sync(frm_sync), .short_frame(1'b1), .sts12_mode(sts12_mode),
    .transparent_mode(transparent_mode), .port_sel(7'h00), .insert_cpu_source_sel(cpu_sel),
    .block_insert_row(cfg.brow), .block_insert_col(cfg.bcol), .single_insert_row(cfg.srow),
    .single_insert_col(cfg.scol), .single_insert_slot(cfg.sslot), .group16_insert_row(cfg.grow),
    .group16_insert_col(cfg.gcol), .group16_third_sel(cfg.gsel), .cpu_wr_en(wr_en),
    .cpu_wr_addr(wr_addr), .cpu_wr_data(wr_data), .ohmon_valid(oh_valid),
    .ohmon_data_in(oh_data), .oh_frame_dv(oh_dv), .tx_data_in(din), .tx_data_out(dout),
    .tx_inserted(ins));

  txobi_oh_source src_u (.sys_clk(sys_clk), .nrst(nrst), .frm_sync(frm_sync), .stall(stall),
    .oh_frame_dv(oh_dv), .ohmon_valid(oh_valid), .ohmon_data_in(oh_data));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic bit hit(logic [3:0] r, logic [1:0] c, int row, int col);
    return r != 0 && c != 0 && r <= 2 && row == r - 1 && col == c - 1;
  endfunction : hit

  task automatic check(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // ----
  // Model of one output byte
  // ----
  task automatic calc(int p, output logic [7:0] v, output logic i);
    int row, col, e;
    row = p / 288;
    col = (p / 48) % 6;
    e = sts12_mode ? (p % 48) & ~3 : p % 48;
    v = din;
    i = 1'b0;
    if (!transparent_mode) begin
      if (hit(lat.brow, lat.bcol, row, col)) begin
        v = act[51 + e];
        i = 1'b1;
      end
      for (int y = 2; y >= 0; y--) begin
        if (hit(lat.grow[4*y+:4], lat.gcol[2*y+:2], row, col) && lat.gsel[2*y+:2] == e / 16 + 1) begin
          v = act[3 + 16 * y + e % 16];
          i = 1'b1;
        end
      end
      // Singles win over every group, so they are applied last
      for (int y = 2; y >= 0; y--) begin
        if (hit(lat.srow[4*y+:4], lat.scol[2*y+:2], row, col) && lat.sslot[6*y+:6] == e) begin
          v = act[y];
          i = 1'b1;
        end
      end
    end
  endtask : calc

  task automatic drive(int f, int p);
    logic [31:0] r;
    r = xs();
    din = r[7:0];
    stall = r[9:8] == 2'b00;
    frm_sync = p == 575;
    if (p == 575) k = 0;
    wr_en = cpu_sel && p > 300 && p < 401;
    wr_addr = 7'(p - 301);
    wr_data = r[31:24];
    if (wr_en && p < 400) stage[p - 301] = r[31:24];
    if (p == 300) begin
      transparent_mode = r[11:10] == 2'b00;
      sts12_mode = r[12];
      cpu_sel = f == 0 || r[13];
      cfg = 66'({xs(), xs(), xs()});
      cfg.brow &= 4'h3;
      cfg.srow &= 12'h333;
      cfg.grow &= 12'h333;
      if (sts12_mode) cfg.sslot &= 18'h3cf3c;
      if (f == 3) begin
        cfg.grow = 12'h222;
        cfg.gcol = 6'h3f;
        cfg.gsel = 6'h39;
        transparent_mode = 1'b0;
      end
      if (cfg.brow == 4'h1 && cfg.bcol == 2'h1) cfg.bcol = 2'h2;
      for (int y = 0; y < 3; y++) begin
        if (cfg.grow[4*y+:4] == 4'h1 && cfg.gcol[2*y+:2] == 2'h1) cfg.gcol[2*y+:2] = 2'h2;
        if (cfg.srow[4*y+:4] == 4'h1 && cfg.scol[2*y+:2] == 2'h1) cfg.scol[2*y+:2] = 2'h2;
      end
    end
  endtask : drive

  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] ev;
    logic ei;
    ev = 8'h00;
    ei = 1'b0;
    repeat (10) @(posedge sys_clk);
    #2 nrst = 1'b1;
    for (int f = 0; f < 12; f++) begin
      for (int p = 0; p < 576; p++) begin
        if (f + p > 0) begin
          check(dout, ev);
          check({7'h00, ins}, {7'h00, ei});
          check({7'h00, oh_dv}, {7'h00, 1'(f > 1 || (f == 1 && p > 0))});
        end
        if (oh_valid && !cpu_sel && k < 99) stage[k] = 8'(k * 7 + 3);
        if (oh_valid) k++;
        drive(f, p);
        calc(p, ev, ei);
        if (p == 0) begin
          act = stage;
          lat = cfg;
        end
        @(posedge sys_clk);
        #2;
      end
    end
    report_and_stop();
  end

  initial begin
    #500000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
